// ---- src/swf_pkg.sv ----
// constants and types of the forwarding controller
package swf_pkg;
  localparam int         NPORT      = 26;
  localparam int         VLAN_N     = 16;
  localparam logic [7:0] A_PORT_CFG = 8'h00;
  localparam logic [7:0] A_ENG_CFG  = 8'h04;
  localparam logic [7:0] A_STATUS   = 8'h08;
  localparam logic [7:0] A_MB_CMD   = 8'h0c;
  localparam logic [7:0] A_MB_LOC1  = 8'h10;
  localparam logic [1:0] A_VLAN_PG  = 2'h1;   // adr[7:6], maps at 0x40..0x7c
  localparam int         B_RX_CUT   = 29;
  localparam int         B_TX_CUT   = 28;
  localparam int         B_VLAN     = 27;
  localparam int         B_CRC      = 24;
  localparam int         B_MB_FAIL  = 31;
  localparam int         H_ID_LSB   = 0;
  localparam int         H_DST_LSB  = 0;
  localparam int         H_ERR_LSB  = 24;
  localparam int         ERR_W      = 4;
  localparam int         MB_OP_LSB  = 24;
  localparam int         ST_Q_LSB   = 8;
  localparam int         ST_TX_LSB  = 16;
  localparam int         ST_MB_LSB  = 20;
  localparam logic [7:0] MB_CMD_TX  = 8'h60;
  localparam logic [6:0] CUT_BYTES  = 7'h40;
  localparam logic [6:0] CUT_WORDS  = 7'h10;
  localparam logic [1:0] HDR_WORDS  = 2'h2;

  typedef enum logic [2:0] {
    MSG_NONE     = 3'h0,
    MSG_SOT      = 3'h1,
    MSG_SOT_CUT  = 3'h2,
    MSG_WR       = 3'h3,
    MSG_HDR_ADDR = 3'h4,
    MSG_HDR_W    = 3'h5
  } swf_msg_e;

  typedef enum logic [1:0] {
    T_IDLE  = 2'h0,
    T_ALERT = 2'h1,
    T_CUT   = 2'h2,
    T_XMIT  = 2'h3
  } swf_tx_e;

  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_READ = 2'h1,
    M_HDR  = 2'h2,
    M_DONE = 2'h3
  } swf_mb_e;
endpackage : swf_pkg

// ---- src/swf_fwd_ctrl.sv ----
// forwarding control: cut-through, multicast, cpu header strobe, mailbox
// Operation
// - cut-through only if rx and dst enabled, queue empty, dst idle.
// - port config bit 29 enables rx cut-through, bit 28 tx cut-through.
// - at 64 received bytes, issue cut-eligible start-of-transfer request.
// - enabled destination latches sender id and enters alert on cut message.
// - bus write words of the sender also load the tx fifo.
// - each further 64 bytes issues another memory write request.
// - cut end enqueues nothing, clears sender, address and id temporaries (crc flag kept), queue stays empty.
// - header error after cut: packet still sent, error counted only.
// - fifo overflow or underflow aborts cut; header later queued normally.
// - vlan off: multicast and broadcast go to all ports.
// - vlan on: permanent-table index selects vlan map for multicast.
// - vlan on without permanent index: packet goes to cpu.
// - header capture strobe pulses at every end-of-packet sequence.
// - header bit 24 requests crc insertion and padding at transmit.
// - transmit command issues combined memory read and lookup request.
// - backpressure at destination: abandon, set mailbox location 1 msb.
// - otherwise emit start address and two header words.
// - after header output signal task completion to the cpu.
// - tx fifo keeps data until 64 bytes are sent.
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module swf_fwd_ctrl #(
  parameter int         FIFO_DEPTH = 64,
  parameter int         Q_DEPTH    = 4,
  parameter logic [4:0] PORT_ID    = 5'h00
) (
  input  logic        clk_i,                  // 100 MHz clock
  input  logic        rst_i,                  // sync reset, high
  input  logic [7:0]  wb_adr_i,               // byte address
  input  logic [31:0] wb_dat_i,               // write data
  output logic [31:0] wb_dat_o,               // read data
  input  logic        wb_we_i,                // write
  input  logic [3:0]  wb_sel_i,               // byte lanes
  input  logic        wb_cyc_i,               // cycle
  input  logic        wb_stb_i,               // strobe
  output logic        wb_ack_o,               // acknowledge
  input  logic        msg_valid_i,            // bus message valid
  input  logic [2:0]  msg_type_i,             // message kind
  input  logic [4:0]  msg_src_i,              // source port id
  input  logic [25:0] msg_dst_i,              // destination bitmap
  input  logic [31:0] msg_data_i,             // word on the bus
  input  logic        mac_rd_i,               // mac takes a word
  input  logic        mac_restart_i,          // mac restart request
  output logic [31:0] mac_data_o,             // word to mac
  output logic        mac_dv_o,               // mac word valid
  input  logic        tx_done_i,              // buffered transmit done
  output logic        tx_start_o,             // start buffered transmit
  output logic [23:0] tx_addr_o,              // packet start address
  output logic [15:0] tx_id_o,                // packet id
  output logic        crc_pad_o,              // insert crc and pad
  output logic        tx_err_stat_o,          // error to tx statistics
  input  logic        rx_start_i,             // new received packet
  input  logic        rx_byte_i,              // byte into rx fifo
  output logic        rx_req_o,               // memory write request
  output logic        rx_cut_o,               // request is cut eligible
  input  logic        lookup_valid_i,         // lookup result valid
  input  logic        lookup_mc_i,            // multicast or broadcast
  input  logic [25:0] lookup_dst_i,           // unicast destinations
  input  logic        perm_hit_i,             // permanent index found
  input  logic [3:0]  perm_idx_i,             // permanent index
  input  logic [25:0] bp_i,                   // per port backpressure
  output logic        fwd_valid_o,            // forward decision valid
  output logic [25:0] fwd_map_o,              // forward port map
  output logic        fwd_cpu_o,              // forward to cpu
  output logic        header_capture_strobe_o, // header capture pulse
  input  logic        host_command_posted_i,  // cpu posted command
  input  logic        mem_rvalid_i,           // memory read word valid
  input  logic [31:0] mem_rdata_i,            // memory read word
  output logic        mb_req_o,               // read and lookup request
  output logic [23:0] mb_addr_o,              // request start address
  output logic        mb_msg_valid_o,         // header message word
  output logic [1:0]  mb_msg_idx_o,           // 0 addr, 1 and 2 header
  output logic [31:0] mb_msg_data_o,          // header message data
  output logic        task_complete_signal_o  // task done pulse
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int QW = $clog2(Q_DEPTH);

  typedef struct packed {
    logic                                           ack;
    logic [31:0]                                    dat;
    logic [31:0]                                    port_cfg;
    logic [31:0]                                    eng_cfg;
    logic [31:0]                                    mb_cmd;
    logic                                           mb_fail;
    logic [swf_pkg::VLAN_N-1:0][swf_pkg::NPORT-1:0] vlan;
    logic [2:0]                                     cmd_sy;
    swf_pkg::swf_tx_e                               ts;
    logic [4:0]                                     tmp_src;
    logic [23:0]                                    tmp_addr;
    logic [15:0]                                    tmp_id;
    logic                                           tmp_crc;
    logic                                           hdr_n;
    logic                                           all_in;
    logic                                           hdr_ok;
    logic [FIFO_DEPTH-1:0][31:0]                    mem;
    logic [PW:0]                                    wp;
    logic [PW:0]                                    rp;
    logic [PW:0]                                    cp;
    logic [6:0]                                     sent;
    logic [Q_DEPTH-1:0][40:0]                       q;
    logic [QW:0]                                    qc;
    logic [31:0]                                    mac_data;
    logic                                           mac_dv;
    logic                                           tx_start;
    logic [40:0]                                    tx_ent;
    logic                                           tx_err;
    logic [7:0]                                     err_cnt;
    logic                                           hstrb;
    logic                                           fwd_valid;
    logic [swf_pkg::NPORT-1:0]                      fwd_map;
    logic                                           fwd_cpu;
    logic [6:0]                                     rx_cnt;
    logic                                           rx_first;
    logic                                           rx_req;
    logic                                           rx_cut;
    swf_pkg::swf_mb_e                               mb;
    logic                                           mb_req;
    logic [23:0]                                    mb_addr;
    logic [1:0][31:0]                               mb_hw;
    logic [1:0]                                     mb_hc;
    logic                                           mb_lk;
    logic                                           mb_bp;
    logic                                           mb_mv;
    logic [1:0]                                     mb_mi;
    logic [1:0]                                     mb_oi;
    logic [31:0]                                    mb_md;
    logic                                           task_done;
  } swf_st_s;

  swf_st_s s;
  swf_st_s n;
  logic [31:0] rd_w;
  logic [31:0] vl_w;
  logic [PW:0] used;
  logic        mv;
  logic        load;
  logic        fault;
  logic        pop;
  logic        hdr_err;
  logic        cmd_edge;

  function automatic logic [31:0] swf_merge(input logic [31:0] o,
                                            input logic [31:0] w,
                                            input logic [3:0]  b);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++) begin
      if (b[k]) r[8*k +: 8] = w[8*k +: 8];
    end
    return r;
  endfunction : swf_merge

  always_comb begin
    n = s;
    n.ack = 1'b0;
    n.mac_dv = 1'b0;
    n.tx_start = 1'b0;
    n.tx_err = 1'b0;
    n.hstrb = 1'b0;
    n.fwd_valid = 1'b0;
    n.rx_req = 1'b0;
    n.mb_req = 1'b0;
    n.mb_mv = 1'b0;
    n.task_done = 1'b0;
    mv = msg_valid_i;
    used = s.wp - s.cp;
    hdr_err = |msg_data_i[swf_pkg::H_ERR_LSB +: swf_pkg::ERR_W];
    pop = 1'b0;
    vl_w = swf_merge(32'(s.vlan[wb_adr_i[5:2]]), wb_dat_i, wb_sel_i);
    // register read mux, unmapped words read zero
    case (wb_adr_i)
      swf_pkg::A_PORT_CFG: rd_w = s.port_cfg;
      swf_pkg::A_ENG_CFG:  rd_w = s.eng_cfg;
      swf_pkg::A_MB_CMD:   rd_w = s.mb_cmd;
      swf_pkg::A_MB_LOC1:  rd_w = {s.mb_fail, 31'h0};
      swf_pkg::A_STATUS:   rd_w = 32'(s.err_cnt)
                              | (32'(s.qc) << swf_pkg::ST_Q_LSB)
                              | (32'(s.ts) << swf_pkg::ST_TX_LSB)
                              | (32'(s.mb) << swf_pkg::ST_MB_LSB);
      default: begin
        if (wb_adr_i[7:6] == swf_pkg::A_VLAN_PG) begin
          rd_w = 32'(s.vlan[wb_adr_i[5:2]]);
        end else begin
          rd_w = 32'h0;
        end
      end
    endcase
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      n.ack = 1'b1;
      n.dat = rd_w;
    end
    // writes land at the edge where the master sees ack
    if (wb_cyc_i && wb_stb_i && s.ack && wb_we_i) begin
      case (wb_adr_i)
        swf_pkg::A_PORT_CFG:
          n.port_cfg = swf_merge(s.port_cfg, wb_dat_i, wb_sel_i);
        swf_pkg::A_ENG_CFG:
          n.eng_cfg = swf_merge(s.eng_cfg, wb_dat_i, wb_sel_i);
        swf_pkg::A_MB_CMD:
          n.mb_cmd = swf_merge(s.mb_cmd, wb_dat_i, wb_sel_i);
        swf_pkg::A_MB_LOC1: begin
          if (wb_sel_i[3]) n.mb_fail = wb_dat_i[swf_pkg::B_MB_FAIL];
        end
        default: begin
          if (wb_adr_i[7:6] == swf_pkg::A_VLAN_PG) begin
            n.vlan[wb_adr_i[5:2]] = vl_w[swf_pkg::NPORT-1:0];
          end
        end
      endcase
    end

    // end-of-packet sequence starts with the header address message
    if (mv && msg_type_i == swf_pkg::MSG_HDR_ADDR) begin
      n.hstrb = 1'b1;
    end

    // transmit controller
    load = s.ts == swf_pkg::T_CUT && mv && msg_type_i == swf_pkg::MSG_WR
         && msg_src_i == s.tmp_src;
    fault = (load && used == (PW+1)'(FIFO_DEPTH))
          || (s.ts == swf_pkg::T_CUT && mac_rd_i && s.rp == s.wp
              && !s.all_in);
    unique case (s.ts)
      swf_pkg::T_IDLE: begin
        if (mv && msg_type_i == swf_pkg::MSG_SOT_CUT && msg_dst_i[PORT_ID]
            && s.port_cfg[swf_pkg::B_TX_CUT]) begin
          n.ts = swf_pkg::T_ALERT;
          n.tmp_src = msg_src_i;
        end else if (s.qc != '0) begin
          pop = 1'b1;
          n.ts = swf_pkg::T_XMIT;
          n.tx_start = 1'b1;
          n.tx_ent = s.q[0];
        end
      end
      swf_pkg::T_ALERT: begin
        if (s.qc == '0) begin
          n.ts = swf_pkg::T_CUT;
          n.wp = '0;
          n.rp = '0;
          n.cp = '0;
          n.sent = '0;
          n.all_in = 1'b0;
          n.hdr_ok = 1'b0;
        end else begin
          n.ts = swf_pkg::T_IDLE;
          n.tmp_src = '0;
        end
      end
      swf_pkg::T_CUT: begin
        if (load && !fault) begin
          n.mem[s.wp[PW-1:0]] = msg_data_i;
          n.wp = s.wp + 1'b1;
        end
        if (mac_rd_i && s.rp != s.wp) begin
          n.mac_data = s.mem[s.rp[PW-1:0]];
          n.mac_dv = 1'b1;
          n.rp = s.rp + 1'b1;
          if (s.sent != swf_pkg::CUT_WORDS) n.sent = s.sent + 1'b1;
        end
        // words stay committed until the collision window has passed
        if (s.sent == swf_pkg::CUT_WORDS) n.cp = s.rp;
        if (mac_restart_i && s.sent != swf_pkg::CUT_WORDS) begin
          n.rp = s.cp;
          n.sent = '0;
        end
        if (fault) begin
          n.ts = swf_pkg::T_IDLE;
          n.tmp_src = '0;
          n.wp = '0;
          n.rp = '0;
          n.cp = '0;
        end else if (s.all_in && s.hdr_ok && s.rp == s.wp) begin
          n.ts = swf_pkg::T_IDLE;
          n.tmp_src = '0;
          n.tmp_addr = '0;
          n.tmp_id = '0;
        end
      end
      swf_pkg::T_XMIT: begin
        if (tx_done_i) n.ts = swf_pkg::T_IDLE;
      end
    endcase
    if (pop) begin
      for (int i = 0; i < Q_DEPTH - 1; i++) begin
        n.q[i] = s.q[i+1];
      end
      n.qc = s.qc - 1'b1;
    end

    // header presentation: address, then two header words
    if (mv && msg_type_i == swf_pkg::MSG_HDR_ADDR) begin
      n.tmp_addr = msg_data_i[23:0];
      n.hdr_n = 1'b0;
      if (s.ts == swf_pkg::T_CUT && msg_src_i == s.tmp_src) n.all_in = 1'b1;
    end
    if (mv && msg_type_i == swf_pkg::MSG_HDR_W) begin
      if (!s.hdr_n) begin
        n.tmp_id = msg_data_i[swf_pkg::H_ID_LSB +: 16];
        n.tmp_crc = msg_data_i[swf_pkg::B_CRC];
        n.hdr_n = 1'b1;
      end else if (msg_data_i[swf_pkg::H_DST_LSB +: 5] == PORT_ID) begin
        n.hdr_n = 1'b0;
        if (s.ts == swf_pkg::T_CUT && !fault) begin
          n.hdr_ok = 1'b1;
          if (hdr_err) begin
            n.tx_err = 1'b1;
            n.err_cnt = s.err_cnt + 1'b1;
          end
        end else if (!hdr_err && n.qc != (QW+1)'(Q_DEPTH)) begin
          n.q[n.qc[QW-1:0]] = {s.tmp_crc, s.tmp_id, s.tmp_addr};
          n.qc = n.qc + 1'b1;
        end
      end
    end

    // forwarding map for unicast, multicast and broadcast
    if (lookup_valid_i) begin
      n.fwd_valid = 1'b1;
      n.fwd_cpu = 1'b0;
      if (!lookup_mc_i) begin
        n.fwd_map = lookup_dst_i;
      end else if (!s.eng_cfg[swf_pkg::B_VLAN]) begin
        n.fwd_map = '1;
      end else if (perm_hit_i) begin
        n.fwd_map = s.vlan[perm_idx_i];
      end else begin
        n.fwd_map = '0;
        n.fwd_cpu = 1'b1;
      end
    end

    // receive side memory write requests
    if (rx_start_i) begin
      n.rx_cnt = '0;
      n.rx_first = 1'b1;
    end else if (rx_byte_i) begin
      n.rx_cnt = s.rx_cnt + 1'b1;
      if (n.rx_cnt == swf_pkg::CUT_BYTES) begin
        n.rx_cnt = '0;
        n.rx_req = 1'b1;
        n.rx_cut = s.rx_first && s.port_cfg[swf_pkg::B_RX_CUT];
        n.rx_first = 1'b0;
      end
    end

    // mailbox controller
    n.cmd_sy = {s.cmd_sy[1:0], host_command_posted_i};
    cmd_edge = s.cmd_sy[1] && !s.cmd_sy[2];
    unique case (s.mb)
      swf_pkg::M_IDLE: begin
        if (cmd_edge && s.mb_cmd[swf_pkg::MB_OP_LSB +: 8]
            == swf_pkg::MB_CMD_TX) begin
          n.mb = swf_pkg::M_READ;
          n.mb_req = 1'b1;
          n.mb_addr = s.mb_cmd[23:0];
          n.mb_hc = '0;
          n.mb_lk = 1'b0;
        end
      end
      swf_pkg::M_READ: begin
        if (mem_rvalid_i && s.mb_hc != swf_pkg::HDR_WORDS) begin
          n.mb_hw[s.mb_hc[0]] = mem_rdata_i;
          n.mb_hc = s.mb_hc + 1'b1;
        end
        if (lookup_valid_i) begin
          n.mb_lk = 1'b1;
          n.mb_bp = |(lookup_dst_i & bp_i);
        end
        if (s.mb_lk && s.mb_hc == swf_pkg::HDR_WORDS) begin
          n.mb_mi = '0;
          if (s.mb_bp) begin
            n.mb = swf_pkg::M_IDLE;
          end else begin
            n.mb = swf_pkg::M_HDR;
          end
        end
      end
      swf_pkg::M_HDR: begin
        n.mb_mv = 1'b1;
        n.mb_oi = s.mb_mi;
        n.mb_mi = s.mb_mi + 1'b1;
        if (s.mb_mi == '0) begin
          n.mb_md = 32'(s.mb_addr);
        end else begin
          n.mb_md = s.mb_hw[s.mb_mi[1]];
        end
        if (s.mb_mi == swf_pkg::HDR_WORDS) n.mb = swf_pkg::M_DONE;
      end
      swf_pkg::M_DONE: begin
        n.task_done = 1'b1;
        n.mb = swf_pkg::M_IDLE;
      end
    endcase
    // hardware set wins over a software clear in the same cycle
    if (s.mb == swf_pkg::M_READ && s.mb_lk && s.mb_bp
        && s.mb_hc == swf_pkg::HDR_WORDS) begin
      n.mb_fail = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign mac_data_o = s.mac_data;
  assign mac_dv_o = s.mac_dv;
  assign tx_start_o = s.tx_start;
  assign tx_addr_o = s.tx_ent[23:0];
  assign tx_id_o = s.tx_ent[39:24];
  assign crc_pad_o = s.tx_ent[40];
  assign tx_err_stat_o = s.tx_err;
  assign rx_req_o = s.rx_req;
  assign rx_cut_o = s.rx_cut;
  assign fwd_valid_o = s.fwd_valid;
  assign fwd_map_o = s.fwd_map;
  assign fwd_cpu_o = s.fwd_cpu;
  assign header_capture_strobe_o = s.hstrb;
  assign mb_req_o = s.mb_req;
  assign mb_addr_o = s.mb_addr;
  assign mb_msg_valid_o = s.mb_mv;
  assign mb_msg_idx_o = s.mb_oi;
  assign mb_msg_data_o = s.mb_md;
  assign task_complete_signal_o = s.task_done;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  alert_entry_a: assert property (
    s.ts == swf_pkg::T_IDLE && mv && msg_type_i == swf_pkg::MSG_SOT_CUT
    && msg_dst_i[PORT_ID] && s.port_cfg[swf_pkg::B_TX_CUT]
    |=> s.ts == swf_pkg::T_ALERT && s.tmp_src == $past(msg_src_i))
    else $error("alert state not entered");
  alert_busy_a: assert property (
    s.ts == swf_pkg::T_ALERT && s.qc != '0 |=> s.ts == swf_pkg::T_IDLE)
    else $error("busy alert did not fall back");
  cut_gate_a: assert property (
    s.ts != swf_pkg::T_CUT ##1 s.ts == swf_pkg::T_CUT
    |-> $past(s.ts) == swf_pkg::T_ALERT && $past(s.qc) == '0)
    else $error("cut entered without its conditions");
  cut_no_queue_a: assert property (
    s.ts == swf_pkg::T_CUT |=> s.qc == $past(s.qc))
    else $error("queue changed during cut");
  cut_abort_a: assert property (
    s.ts == swf_pkg::T_CUT && fault |=> s.ts == swf_pkg::T_IDLE)
    else $error("fifo fault did not abort cut");
  hdr_strobe_a: assert property (
    mv && msg_type_i == swf_pkg::MSG_HDR_ADDR |=> header_capture_strobe_o)
    else $error("header strobe missing");
  vlan_off_a: assert property (
    lookup_valid_i && lookup_mc_i && !s.eng_cfg[swf_pkg::B_VLAN]
    |=> fwd_valid_o && &fwd_map_o && !fwd_cpu_o)
    else $error("flood map wrong");
  vlan_miss_a: assert property (
    lookup_valid_i && lookup_mc_i && s.eng_cfg[swf_pkg::B_VLAN]
    && !perm_hit_i |=> fwd_cpu_o && fwd_map_o == '0)
    else $error("unresolved packet not sent to cpu");
  mb_backoff_a: assert property (
    s.mb == swf_pkg::M_READ && s.mb_lk && s.mb_bp
    && s.mb_hc == swf_pkg::HDR_WORDS
    |=> (s.mb_fail && s.mb == swf_pkg::M_IDLE) ##0 (!mb_msg_valid_o)[*3])
    else $error("backpressure did not abandon transmit");
  task_done_a: assert property (
    s.mb == swf_pkg::M_HDR && s.mb_mi == '0
    |=> mb_msg_valid_o [*3] ##1 task_complete_signal_o)
    else $error("task completion not after header");
endmodule : swf_fwd_ctrl

// ---- dv/swf_host_model.sv ----
// cpu side model: posts mailbox commands, serves the header read
`timescale 1ns/1ps
module swf_host_model (
  input  wire logic        clk_i,    // clock
  input  wire logic        go_i,     // mailbox command written
  input  wire logic        req_i,    // read and lookup request
  output logic             posted_o, // command posted level
  output logic             rvalid_o, // read word valid
  output logic [31:0]      rdata_o   // read word
);
  logic [1:0] n_q = 2'h0;
  initial begin
    posted_o = 1'b0;
    rvalid_o = 1'b0;
    rdata_o  = 32'h0;
  end
  always @(posedge clk_i) begin
    posted_o <= go_i;
    rvalid_o <= n_q != 2'h0;
    n_q      <= req_i ? 2'h2 : (n_q != 2'h0 ? n_q - 2'h1 : 2'h0);
    // full first word (id, crc flag), then port 0; released bus toggles
    rdata_o  <= n_q == 2'h2 ? 32'h010000a5 :
                n_q == 2'h1 ? 32'h0 : ~rdata_o;
  end
endmodule : swf_host_model

// ---- dv/swf_fwd_ctrl_tb.sv ----
// self-checking bench of the forwarding controller
`timescale 1ns/1ps
module swf_fwd_ctrl_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0, msg_valid_i = 1'b0, mac_rd_i = 1'b0, go = 1'b0;
  logic mac_restart_i = 1'b0, tx_done_i = 1'b0, rx_start_i = 1'b0;
  logic rx_byte_i = 1'b0, lookup_valid_i = 1'b0, lookup_mc_i = 1'b0;
  logic perm_hit_i = 1'b0, host_command_posted_i, mem_rvalid_i, cut_seen;
  logic wb_ack_o, mac_dv_o, tx_start_o, crc_pad_o, tx_err_stat_o, rx_req_o;
  logic rx_cut_o, fwd_valid_o, fwd_cpu_o, header_capture_strobe_o, mb_req_o;
  logic mb_msg_valid_o, task_complete_signal_o;
  logic [3:0]  wb_sel_i = 4'hf, perm_idx_i = 4'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, msg_data_i = 32'h0, wb_dat_o, mac_data_o;
  logic [31:0] mem_rdata_i, mb_msg_data_o, q;
  logic [2:0]  msg_type_i = 3'h0;
  logic [4:0]  msg_src_i = 5'h5;
  logic [25:0] msg_dst_i = 26'h1, lookup_dst_i = 26'h1, bp_i = 26'h0;
  logic [25:0] fwd_map_o;
  logic [23:0] tx_addr_o, mb_addr_o;
  logic [15:0] tx_id_o;
  logic [1:0]  mb_msg_idx_o;
  int mismatches = 0, check_count = 0;
  logic [31:0] n_hs = 32'h0, n_te = 32'h0, n_ts = 32'h0, n_rq = 32'h0;
  logic [31:0] n_mv = 32'h0, n_tc = 32'h0, br_pr, br_ad, br_w1, br_w2;
  logic br_go = 1'b0;
  localparam logic [71:0] ROWS [5] = '{{8'h00, 32'h30000000, 32'h30000000},
    {8'h04, 32'h08000000, 32'h08000000}, {8'h40, 32'h5, 32'h5},
    {8'h0c, 32'h60001000, 32'h60001000}, {8'h20, 32'hffffffff, 32'h0}};

  swf_fwd_ctrl swf_fwd_ctrl_i (.*);
  swf_host_model swf_host_model_i (.clk_i(clk_i), .go_i(go),
    .req_i(mb_req_o), .posted_o(host_command_posted_i),
    .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (rx_req_o && n_rq == 0) cut_seen = rx_cut_o;
    n_rq += rx_req_o;
    n_hs += header_capture_strobe_o;
    n_te += tx_err_stat_o;
    n_ts += tx_start_o;
    n_mv += mb_msg_valid_o;
    n_tc += task_complete_signal_o;
    // bridge: address, then two header words after each strobe
    if (br_go) br_w2 = msg_data_i;
    br_go = header_capture_strobe_o;
    if (br_go) {br_ad, br_w1} = {br_pr, msg_data_i};
    br_pr = msg_data_i;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    {wb_adr_i, wb_we_i, wb_dat_i} <= {a, w, d};
    {wb_cyc_i, wb_stb_i} <= 2'h3;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb

  task automatic m(input logic [2:0] t, input logic [31:0] d);
    @(posedge clk_i);
    {msg_valid_i, msg_type_i, msg_data_i} <= {1'b1, t, d};
  endtask : m

  task automatic lk(input logic hit);
    @(posedge clk_i);
    {perm_hit_i, lookup_valid_i} <= {hit, 1'b1};
    @(posedge clk_i) lookup_valid_i <= 1'b0;
    while (fwd_valid_o !== 1'b1) @(posedge clk_i);
  endtask : lk

  task automatic mb(input logic fwd);
    wb(8'h0c, 1'b1, 32'h60001000);
    @(posedge clk_i) go <= 1'b1;
    while (mb_req_o !== 1'b1) @(posedge clk_i);
    chk({8'h0, mb_addr_o}, 32'h1000);
    repeat (4) @(posedge clk_i);
    lk(1'b0);
    if (fwd) begin
      // the header message goes out on the shared bus to all ports
      while (mb_msg_valid_o !== 1'b1) @(posedge clk_i);
      while (mb_msg_valid_o === 1'b1) begin
        {msg_valid_i, msg_type_i, msg_data_i} <= {1'b1,
          (mb_msg_idx_o == 2'h0 ? 3'h4 : 3'h5), mb_msg_data_o};
        @(posedge clk_i);
      end
      msg_valid_i <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    go <= 1'b0;
  endtask : mb

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  initial begin
    #50us;
    mismatches++;
    stop_test;
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ROWS[i]) begin
      wb(ROWS[i][71:64], 1'b1, ROWS[i][63:32]);
      wb(ROWS[i][71:64], 1'b0, 32'h0);
      chk(q, ROWS[i][31:0]);
    end
    $display("registers done");
    lookup_mc_i <= 1'b1;
    lk(1'b0);
    chk({31'h0, fwd_cpu_o}, 32'h1);
    lk(1'b1);
    chk({6'h0, fwd_map_o}, 32'h5);
    wb(8'h04, 1'b1, 32'h0);
    lk(1'b1);
    chk({6'h0, fwd_map_o}, 32'h3ffffff);
    lookup_mc_i <= 1'b0;
    $display("multicast done");
    @(posedge clk_i) rx_start_i <= 1'b1;
    for (int i = 0; i < 128; i++) begin
      @(posedge clk_i) {rx_start_i, rx_byte_i} <= 2'h1;
    end
    @(posedge clk_i) rx_byte_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(n_rq, 2);
    chk({31'h0, cut_seen}, 32'h1);
    m(3'h2, 32'h0);
    @(posedge clk_i) msg_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 16; i++) m(3'h3, 32'hc0de0000 + i);
    m(3'h4, 32'h1000);
    m(3'h5, 32'ha5);
    m(3'h5, 32'h01000000);
    @(posedge clk_i) msg_valid_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i) mac_rd_i <= 1'b1;
      @(posedge clk_i) mac_rd_i <= 1'b0;
      @(posedge clk_i) chk(mac_data_o, 32'hc0de0000 + i);
      chk({31'h0, mac_dv_o}, 32'h1);
    end
    chk(n_hs, 1);
    chk(br_ad, 32'h1000);
    chk(br_w1, 32'ha5);
    chk(br_w2, 32'h01000000);
    chk(n_te, 1);
    chk(n_ts, 0);
    wb(8'h08, 1'b0, 32'h0);
    chk(q & 32'h30f00, 32'h0);
    $display("cut-through done");
    bp_i <= 26'h1;
    mb(1'b0);
    wb(8'h10, 1'b0, 32'h0);
    chk({31'h0, q[31]}, 32'h1);
    chk(n_mv + n_tc, 0);
    wb(8'h10, 1'b1, 32'h0);
    bp_i <= 26'h0;
    mb(1'b1);
    chk(n_mv, 3);
    chk(n_tc, 1);
    chk(n_ts, 1);
    chk({tx_addr_o, tx_id_o[7:0]}, 32'h1000a5);
    chk({31'h0, crc_pad_o}, 32'h1);
    $display("mailbox done");
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(8'h00, 1'b0, 32'h0);
    chk(q, 32'h0);
    $display("reset done");
    stop_test;
  end
endmodule : swf_fwd_ctrl_tb
